// file: dsi_a_err_map.vh
// Offsets, field positions and reset values of the channel A error status registers
`ifndef DSI_A_ERR_MAP_VH
`define DSI_A_ERR_MAP_VH

// Target address on the two-wire register port
`define TARGET_ADDR          7'h2d

// Register offsets
`define LINK_STAT_OFS        8'hf0
`define PKT_STAT_OFS         8'hf1
`define ERR_FIRST_OFS        8'hf0
`define ERR_LAST_OFS         8'hf8

// Link status field positions
`define LNK_CONTENTION_BIT   7
`define LNK_FALSE_CTRL_BIT   6
`define LNK_TIMER_BIT        5
`define LNK_LP_ALIGN_BIT     4
`define LNK_ESCAPE_BIT       3
`define LNK_END_ALIGN_BIT    2
`define LNK_START_SYNC_BIT   1
`define LNK_START_LEAD_BIT   0

// Packet status field positions
`define PKT_PROTOCOL_BIT     7
`define PKT_BAD_LENGTH_BIT   5
`define PKT_UNKNOWN_TYPE_BIT 3
`define PKT_PAYLOAD_CRC_BIT  2
`define PKT_HDR_UNCORR_BIT   1
`define PKT_HDR_CORR_BIT     0

// Reserved packet status positions
`define PKT_RSV_HI_BIT       6
`define PKT_RSV_LO_BIT       4

// Implemented bits (bits 6 and 4 of packet status are reserved)
`define LINK_IMPL_MASK       8'hff
`define PKT_IMPL_MASK        8'haf

// Reset values
`define LINK_STAT_RST        8'h00
`define PKT_STAT_RST         8'h00

`endif

// file: sync2.v
// Two flip-flop synchroniser for signals arriving from outside the core clock
`timescale 1ns/100ps
`default_nettype none

module sync2 #(
	parameter WIDTH = 1,
	parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
	input  wire             clk_i,
	input  wire             rst_b_i,
	input  wire [WIDTH-1:0] async_i,
	output wire [WIDTH-1:0] sync_o
);

	reg [WIDTH-1:0] meta_q;
	reg [WIDTH-1:0] sync_q;

	always @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			meta_q <= RST_VAL;
			sync_q <= RST_VAL;
		end else begin
			meta_q <= async_i;
			sync_q <= meta_q;
		end
	end

	assign sync_o = sync_q;

endmodule // sync2

`default_nettype wire

// file: dsi_a_error_status.v
// Channel A error status registers behind a two-wire target register port
//
// Overview of operation
// - Line contention fault on channel A sets link status bit 7.
// - Incomplete escape/turnaround or high-speed request without bridge state sets bit 6.
// - High-speed receive or low-power transmit timer expiry sets bit 5.
// - Low-power end data not byte aligned sets bit 4.
// - Unknown escape entry sets bit 3; auto-cleared only by the read acknowledge report.
// - High-speed final byte off byte boundary sets bit 2.
// - Corrupted start of transmission, sync lost, sets bit 1.
// - Start-of-transmission leader bit error sets link status bit 0.
// - Packet protocol error sets packet status bit 7.
// - Invalid transmission length sets packet bit 5; bits 6 and 4 reserved.
// - Unrecognized data type sets packet status bit 3.
// - Payload checksum mismatch sets packet status bit 2.
// - Uncorrectable header ECC error sets packet status bit 1.
// - Corrected single header ECC error sets packet status bit 0.
// - Other flags clear on write of 1 or on any acknowledge-and-error report.
// - Status registers sit inside the error register range 0xf0 to 0xf8.
`timescale 1ns/100ps
`default_nettype none
`include "dsi_a_err_map.vh"

module dsi_a_error_status #(
	parameter [6:0] TARGET_ADDR = `TARGET_ADDR
) (
	input  wire       core_clk_i,
	input  wire       rst_b_i,
	input  wire       scl_i,
	input  wire       sda_i,
	output wire       sda_o,
	output wire       sda_oe_o,
	input  wire       a_line_contention_evt_i,
	input  wire       a_false_control_evt_i,
	input  wire       a_hs_rx_timer_evt_i,
	input  wire       a_lp_tx_timer_evt_i,
	input  wire       a_lowpower_align_evt_i,
	input  wire       a_escape_entry_evt_i,
	input  wire       a_end_align_evt_i,
	input  wire       a_start_sync_evt_i,
	input  wire       a_start_leader_evt_i,
	input  wire       a_protocol_evt_i,
	input  wire       a_bad_length_evt_i,
	input  wire       a_unknown_type_evt_i,
	input  wire       a_payload_crc_evt_i,
	input  wire       a_header_uncorrectable_evt_i,
	input  wire       a_header_corrected_evt_i,
	input  wire       ack_report_read_i,
	input  wire       ack_report_write_i,
	output wire [7:0] link_status_o,
	output wire [7:0] packet_status_o
);

	localparam [2:0] S_IDLE = 3'd0;
	localparam [2:0] S_RX   = 3'd1;
	localparam [2:0] S_ACK  = 3'd2;
	localparam [2:0] S_TX   = 3'd3;
	localparam [2:0] S_MACK = 3'd4;

	localparam [1:0] K_ADDR = 2'd0;
	localparam [1:0] K_PTR  = 2'd1;
	localparam [1:0] K_DATA = 2'd2;

	// Reset value of every flag, packet status in the upper half
	localparam [15:0] FLAG_RST = {`PKT_STAT_RST, `LINK_STAT_RST};

	reg        rst_meta_q;
	reg        rst_sync_q;
	wire       rst_b;

	wire [1:0] pins_s;
	wire       scl_s;
	wire       sda_s;
	reg        scl_p_q;
	reg        sda_p_q;
	wire       scl_rise;
	wire       scl_fall;
	wire       bus_start;
	wire       bus_stop;

	reg  [2:0] state_q;
	reg  [1:0] kind_q;
	reg  [3:0] bit_cnt_q;
	reg  [7:0] shift_q;
	reg  [7:0] ptr_q;
	reg        rw_q;
	reg        drive_low_q;
	reg        wr_stb_q;
	reg  [7:0] wr_addr_q;
	reg  [7:0] wr_data_q;
	reg  [7:0] rdata;

	wire [15:0] set_vec;
	wire [15:0] impl_mask;
	wire [15:0] w1c_vec;
	wire [15:0] auto_clr_vec;
	wire [15:0] flag_vec;
	reg  [7:0]  link_flags;

	// Reset release through two flip-flops
	always @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end

	assign rst_b = rst_sync_q;

	// Bus pins idle high
	// No clock stretching: every bus phase must outlast the three-cycle
	// path through the synchroniser and the edge flops
	sync2 #(
		.WIDTH   (2),
		.RST_VAL (2'b11)
	) u_pin_sync (
		.clk_i   (core_clk_i),
		.rst_b_i (rst_b),
		.async_i ({scl_i, sda_i}),
		.sync_o  (pins_s)
	);

	assign scl_s = pins_s[1];
	assign sda_s = pins_s[0];

	always @(posedge core_clk_i or negedge rst_b) begin
		if (!rst_b) begin
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
		end else begin
			scl_p_q <= scl_s;
			sda_p_q <= sda_s;
		end
	end

	assign scl_rise  = scl_s & ~scl_p_q;
	assign scl_fall  = ~scl_s & scl_p_q;
	assign bus_start = scl_s & scl_p_q & sda_p_q & ~sda_s;
	assign bus_stop  = scl_s & scl_p_q & ~sda_p_q & sda_s;

	// Read data for the current pointer; all other offsets read zero
	// Pointer moves on after each byte, so a burst read walks the registers
	always @* begin
		rdata = 8'h00;
		case (ptr_q)
			`LINK_STAT_OFS: begin
				rdata = link_flags;
			end
			`PKT_STAT_OFS: begin
				rdata = flag_vec[15:8] & `PKT_IMPL_MASK;
			end
			default: begin
				rdata = 8'h00;
			end
		endcase
	end

	// Target protocol: address byte, register pointer, then data bytes
	always @(posedge core_clk_i or negedge rst_b) begin
		if (!rst_b) begin
			state_q     <= S_IDLE;
			kind_q      <= K_ADDR;
			bit_cnt_q   <= 4'h0;
			shift_q     <= 8'h00;
			ptr_q       <= 8'h00;
			rw_q        <= 1'b0;
			drive_low_q <= 1'b0;
			wr_stb_q    <= 1'b0;
			wr_addr_q   <= 8'h00;
			wr_data_q   <= 8'h00;
		end else begin
			wr_stb_q <= 1'b0;
			if (bus_start) begin
				state_q     <= S_RX;
				kind_q      <= K_ADDR;
				bit_cnt_q   <= 4'h0;
				drive_low_q <= 1'b0;
			end else if (bus_stop) begin
				state_q     <= S_IDLE;
				drive_low_q <= 1'b0;
			end else begin
				case (state_q)
					S_IDLE: begin
						drive_low_q <= 1'b0;
					end
					S_RX: begin
						if (scl_rise && bit_cnt_q != 4'd8) begin
							shift_q   <= {shift_q[6:0], sda_s};
							bit_cnt_q <= bit_cnt_q + 4'd1;
						end else if (scl_fall && bit_cnt_q == 4'd8) begin
							bit_cnt_q <= 4'h0;
							case (kind_q)
								K_ADDR: begin
									if (shift_q[7:1] == TARGET_ADDR) begin
										rw_q        <= shift_q[0];
										kind_q      <= K_PTR;
										drive_low_q <= 1'b1;
										state_q     <= S_ACK;
									end else begin
										// Not ours: stay off the bus until the next start
										state_q <= S_IDLE;
									end
								end
								K_PTR: begin
									ptr_q       <= shift_q;
									kind_q      <= K_DATA;
									drive_low_q <= 1'b1;
									state_q     <= S_ACK;
								end
								default: begin
									wr_stb_q    <= 1'b1;
									wr_addr_q   <= ptr_q;
									wr_data_q   <= shift_q;
									ptr_q       <= ptr_q + 8'h01;
									drive_low_q <= 1'b1;
									state_q     <= S_ACK;
								end
							endcase
						end
					end
					S_ACK: begin
						if (scl_fall) begin
							if (rw_q) begin
								// Read after address: first data bit goes out now
								drive_low_q <= ~rdata[7];
								shift_q     <= {rdata[6:0], 1'b0};
								bit_cnt_q   <= 4'd1;
								ptr_q       <= ptr_q + 8'h01;
								state_q     <= S_TX;
							end else begin
								drive_low_q <= 1'b0;
								bit_cnt_q   <= 4'h0;
								state_q     <= S_RX;
							end
						end
					end
					S_TX: begin
						if (scl_fall) begin
							if (bit_cnt_q == 4'd8) begin
								drive_low_q <= 1'b0;
								state_q     <= S_MACK;
							end else begin
								drive_low_q <= ~shift_q[7];
								shift_q     <= {shift_q[6:0], 1'b0};
								bit_cnt_q   <= bit_cnt_q + 4'd1;
							end
						end
					end
					S_MACK: begin
						if (scl_rise && sda_s) begin
							// Host declined more data
							state_q <= S_IDLE;
						end else if (scl_fall) begin
							// Host acknowledged: next register goes out
							drive_low_q <= ~rdata[7];
							shift_q     <= {rdata[6:0], 1'b0};
							bit_cnt_q   <= 4'd1;
							ptr_q       <= ptr_q + 8'h01;
							state_q     <= S_TX;
						end
					end
					default: begin
						state_q     <= S_IDLE;
						drive_low_q <= 1'b0;
					end
				endcase
			end
		end
	end

	assign sda_o    = 1'b0;
	assign sda_oe_o = drive_low_q;

	// Event sources, packet status in the upper half
	assign set_vec[`LNK_CONTENTION_BIT]   = a_line_contention_evt_i;
	assign set_vec[`LNK_FALSE_CTRL_BIT]   = a_false_control_evt_i;
	assign set_vec[`LNK_TIMER_BIT]        = a_hs_rx_timer_evt_i | a_lp_tx_timer_evt_i;
	assign set_vec[`LNK_LP_ALIGN_BIT]     = a_lowpower_align_evt_i;
	assign set_vec[`LNK_ESCAPE_BIT]       = a_escape_entry_evt_i;
	assign set_vec[`LNK_END_ALIGN_BIT]    = a_end_align_evt_i;
	assign set_vec[`LNK_START_SYNC_BIT]   = a_start_sync_evt_i;
	assign set_vec[`LNK_START_LEAD_BIT]   = a_start_leader_evt_i;
	assign set_vec[8+`PKT_PROTOCOL_BIT]   = a_protocol_evt_i;
	assign set_vec[8+`PKT_RSV_HI_BIT]     = 1'b0;
	assign set_vec[8+`PKT_BAD_LENGTH_BIT] = a_bad_length_evt_i;
	assign set_vec[8+`PKT_RSV_LO_BIT]     = 1'b0;
	assign set_vec[8+`PKT_UNKNOWN_TYPE_BIT] = a_unknown_type_evt_i;
	assign set_vec[8+`PKT_PAYLOAD_CRC_BIT]  = a_payload_crc_evt_i;
	assign set_vec[8+`PKT_HDR_UNCORR_BIT]   = a_header_uncorrectable_evt_i;
	assign set_vec[8+`PKT_HDR_CORR_BIT]     = a_header_corrected_evt_i;

	assign impl_mask = {`PKT_IMPL_MASK, `LINK_IMPL_MASK};

	// Write-one-to-clear; zeros leave flags untouched
	assign w1c_vec[7:0]  = (wr_stb_q && wr_addr_q == `LINK_STAT_OFS) ?
		wr_data_q : 8'h00;
	assign w1c_vec[15:8] = (wr_stb_q && wr_addr_q == `PKT_STAT_OFS) ?
		wr_data_q : 8'h00;

	// Escape entry flag ignores acknowledge reports for generic writes
	genvar gi;
	generate
		for (gi = 0; gi < 16; gi = gi + 1) begin : g_flag
			reg  flag_q;
			wire flag_d;
			if (gi == `LNK_ESCAPE_BIT) begin : g_esc
				assign auto_clr_vec[gi] = ack_report_read_i;
			end else begin : g_std
				assign auto_clr_vec[gi] = ack_report_read_i | ack_report_write_i;
			end
			// A set in the same cycle as a clear wins
			assign flag_d = set_vec[gi] |
				(flag_q & ~(w1c_vec[gi] | auto_clr_vec[gi]));
			always @(posedge core_clk_i or negedge rst_b) begin
				if (!rst_b) begin
					flag_q <= FLAG_RST[gi];
				end else if (impl_mask[gi]) begin
					flag_q <= flag_d;
				end else begin
					flag_q <= 1'b0;
				end
			end
			assign flag_vec[gi] = flag_q;
		end
	endgenerate

	always @* begin
		link_flags = flag_vec[7:0];
	end

	assign link_status_o   = flag_vec[7:0];
	assign packet_status_o = flag_vec[15:8];

endmodule // dsi_a_error_status

`default_nettype wire

// file: dsi_a_err_props.sv
// Assertions on the channel A error status ports
`timescale 1ns/100ps
`default_nettype none
module dsi_a_err_props (
	input wire logic       core_clk_i,
	input wire logic       rst_b_i,
	input wire logic       sda_oe_o,
	input wire logic       a_line_contention_evt_i,
	input wire logic       a_false_control_evt_i,
	input wire logic       a_hs_rx_timer_evt_i,
	input wire logic       a_lp_tx_timer_evt_i,
	input wire logic       a_protocol_evt_i,
	input wire logic       ack_report_read_i,
	input wire logic       ack_report_write_i,
	input wire logic [7:0] link_status_o,
	input wire logic [7:0] packet_status_o
);
	logic [3:0] live_q;
	// Covers the internal two-flop reset release
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i)
			live_q <= 4'h0;
		else
			live_q <= {live_q[2:0], 1'b1};
	end
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!live_q[3]);
	property p_cont; a_line_contention_evt_i |=> link_status_o[7]; endproperty
	a_cont: assert property (p_cont) else $error("contention not set");
	property p_fctl; a_false_control_evt_i |=> link_status_o[6]; endproperty
	a_fctl: assert property (p_fctl) else $error("false control not set");
	property p_tmr; a_hs_rx_timer_evt_i || a_lp_tx_timer_evt_i |=> link_status_o[5]; endproperty
	a_tmr: assert property (p_tmr) else $error("timer not set");
	property p_esc;
		ack_report_write_i && !ack_report_read_i && !sda_oe_o && link_status_o[3]
			|=> link_status_o[3];
	endproperty
	a_esc: assert property (p_esc) else $error("escape cleared by write");
	property p_clr; ack_report_read_i && !a_line_contention_evt_i |=> !link_status_o[7]; endproperty
	a_clr: assert property (p_clr) else $error("report did not clear");
	property p_stick;
		!ack_report_read_i && !ack_report_write_i && !sda_oe_o
			|=> (link_status_o & $past(link_status_o)) == $past(link_status_o)
			&& (packet_status_o & $past(packet_status_o)) == $past(packet_status_o);
	endproperty
	a_stick: assert property (p_stick) else $error("flag dropped");
	property p_win; a_protocol_evt_i && ack_report_read_i |=> packet_status_o[7]; endproperty
	a_win: assert property (p_win) else $error("set lost to clear");
	property p_rsv; packet_status_o[6] == 1'b0 && packet_status_o[4] == 1'b0; endproperty
	a_rsv: assert property (p_rsv) else $error("reserved bit set");
	c_clr: cover property (ack_report_read_i && link_status_o != 8'h00);
	c_esc: cover property (ack_report_write_i && link_status_o[3]);
	c_ack: cover property ($rose(sda_oe_o));
endmodule // dsi_a_err_props
bind dsi_a_error_status dsi_a_err_props u_props (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
	.sda_oe_o(sda_oe_o), .a_line_contention_evt_i(a_line_contention_evt_i),
	.a_false_control_evt_i(a_false_control_evt_i), .a_hs_rx_timer_evt_i(a_hs_rx_timer_evt_i),
	.a_lp_tx_timer_evt_i(a_lp_tx_timer_evt_i), .a_protocol_evt_i(a_protocol_evt_i),
	.ack_report_read_i(ack_report_read_i), .ack_report_write_i(ack_report_write_i),
	.link_status_o(link_status_o), .packet_status_o(packet_status_o));
`default_nettype wire

// file: i2c_host_model.sv
// Two-wire host model driving the register port
`timescale 1ns/100ps
`default_nettype none
module i2c_host_model (
	input  wire logic clk_i,
	input  wire logic sda_i,
	output var  logic scl_o,
	output var  logic sda_o
);
	// Clock idles high between frames, 200 ns period inside them
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end
	task automatic hc(input int n);
		repeat (n) @(negedge clk_i);
	endtask
	task automatic start;
		sda_o = 1'b1;
		hc(4);
		scl_o = 1'b1;
		hc(4);
		sda_o = 1'b0;
		hc(4);
		scl_o = 1'b0;
	endtask
	task automatic stop;
		hc(1);
		sda_o = 1'b0;
		hc(3);
		scl_o = 1'b1;
		hc(4);
		sda_o = 1'b1;
		hc(4);
	endtask
	// Sampled late in the high phase to allow the target's sync latency
	task automatic bitx(input logic b, output logic r);
		hc(1);
		sda_o = b;
		hc(3);
		scl_o = 1'b1;
		hc(4);
		r = sda_i;
		scl_o = 1'b0;
	endtask
	task automatic xfer(input logic [7:0] w, output logic [7:0] r, input logic nak,
		output logic ack);
		logic a;
		for (int i = 7; i >= 0; i--)
			bitx(w[i], r[i]);
		bitx(nak, a);
		ack = !a;
	endtask
endmodule // i2c_host_model
`default_nettype wire

// file: dsi_a_error_status_tb_top.sv
// Testbench for the channel A error status registers
`timescale 1ns/100ps
`default_nettype none
`include "dsi_a_err_map.vh"
module dsi_a_error_status_tb_top;
	logic        clk;
	logic        rst_b;
	logic [14:0] ev;
	logic        rdr;
	logic        wrr;
	logic [7:0]  exp_l;
	logic [7:0]  exp_p;
	logic [7:0]  v;
	logic        ack;
	wire  [7:0]  link;
	wire  [7:0]  pkt;
	wire         scl;
	wire         h_sda;
	wire         d_sda;
	wire         oe;
	wire         sda_w;
	int          errors;
	int          n_checks;
	assign sda_w = h_sda & (oe ? d_sda : 1'b1);
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	i2c_host_model host (.clk_i(clk), .sda_i(sda_w), .scl_o(scl), .sda_o(h_sda));
	dsi_a_error_status uut (.core_clk_i(clk), .rst_b_i(rst_b), .scl_i(scl), .sda_i(sda_w),
		.sda_o(d_sda), .sda_oe_o(oe), .a_line_contention_evt_i(ev[0]),
		.a_false_control_evt_i(ev[1]), .a_hs_rx_timer_evt_i(ev[2]), .a_lp_tx_timer_evt_i(ev[3]),
		.a_lowpower_align_evt_i(ev[4]), .a_escape_entry_evt_i(ev[5]), .a_end_align_evt_i(ev[6]),
		.a_start_sync_evt_i(ev[7]), .a_start_leader_evt_i(ev[8]), .a_protocol_evt_i(ev[9]),
		.a_bad_length_evt_i(ev[10]), .a_unknown_type_evt_i(ev[11]), .a_payload_crc_evt_i(ev[12]),
		.a_header_uncorrectable_evt_i(ev[13]), .a_header_corrected_evt_i(ev[14]),
		.ack_report_read_i(rdr), .ack_report_write_i(wrr), .link_status_o(link),
		.packet_status_o(pkt));
	task automatic end_sim;
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Random set pulses and report clears, model updated each cycle
	task automatic step(input int n, input logic all);
		for (int i = 0; i < n; i++) begin
			ev = all ? 15'h7fff : 15'($urandom & $urandom & $urandom);
			rdr = !all && ($urandom % 8) == 0;
			wrr = !all && ($urandom % 8) == 0;
			exp_l = (exp_l & ~(rdr ? 8'hff : wrr ? 8'hf7 : 8'h00))
				| {ev[0], ev[1], ev[2] | ev[3], ev[4], ev[5], ev[6], ev[7], ev[8]};
			exp_p = (exp_p & ~((rdr | wrr) ? 8'hff : 8'h00))
				| {ev[9], 1'b0, ev[10], 1'b0, ev[11], ev[12], ev[13], ev[14]};
			@(negedge clk);
			chk(link, exp_l);
			chk(pkt, exp_p);
		end
		ev = 15'h0000;
		rdr = 1'b0;
		wrr = 1'b0;
	endtask
	task automatic wr(input logic [7:0] ofs, input logic [7:0] d0, input logic [7:0] d1);
		host.start();
		host.xfer({`TARGET_ADDR, 1'b0}, v, 1'b1, ack);
		chk({7'h00, ack}, 8'h01);
		host.xfer(ofs, v, 1'b1, ack);
		chk({7'h00, ack}, 8'h01);
		host.xfer(d0, v, 1'b1, ack);
		chk({7'h00, ack}, 8'h01);
		host.xfer(d1, v, 1'b1, ack);
		chk({7'h00, ack}, 8'h01);
		host.stop();
	endtask
	// Burst read: host acknowledges the first byte and refuses the second
	task automatic rd(input logic [7:0] ofs, input logic [7:0] e0, input logic [7:0] e1);
		host.start();
		host.xfer({`TARGET_ADDR, 1'b0}, v, 1'b1, ack);
		host.xfer(ofs, v, 1'b1, ack);
		host.start();
		host.xfer({`TARGET_ADDR, 1'b1}, v, 1'b1, ack);
		chk({7'h00, ack}, 8'h01);
		host.xfer(8'hff, v, 1'b0, ack);
		chk(v, e0);
		host.xfer(8'hff, v, 1'b1, ack);
		chk(v, e1);
		host.stop();
	endtask
	initial begin
		repeat (60000) @(posedge clk);
		errors++;
		end_sim();
	end
	initial begin
		{errors, n_checks} = '0;
		{ev, rdr, wrr, exp_l, exp_p, rst_b} = '0;
		repeat (5) @(posedge clk);
		@(negedge clk);
		rst_b = 1'b1;
		repeat (6) @(negedge clk);
		chk(link, `LINK_STAT_RST);
		chk(pkt, `PKT_STAT_RST);
		void'($urandom(30967));
		step(400, 1'b0);
		step(1, 1'b1);
		wr(`LINK_STAT_OFS, 8'h81, 8'h50);
		exp_l = 8'h7e;
		rd(`LINK_STAT_OFS, exp_l, exp_p);
		rd(`PKT_STAT_OFS, exp_p, 8'h00);
		wr(`PKT_STAT_OFS, 8'h0f, 8'hff);
		exp_p = 8'ha0;
		rd(`PKT_STAT_OFS, exp_p, 8'h00);
		rd(8'hf2, 8'h00, 8'h00);
		rd(`ERR_LAST_OFS, 8'h00, 8'h00);
		host.start();
		host.xfer({7'h2c, 1'b0}, v, 1'b1, ack);
		chk({7'h00, ack}, 8'h00);
		host.stop();
		step(300, 1'b0);
		end_sim();
	end
endmodule // dsi_a_error_status_tb_top
`default_nettype wire
